// ==== src/fpk_pkg.sv ====
// shared constants for the front-panel key scanner
`default_nettype none
package fpk_pkg;
  // ----------------------------------------
  // bus offsets
  // ----------------------------------------
  localparam logic [7:0] FPK_OFF_POLL = 8'h00;
  localparam logic [7:0] FPK_OFF_STATUS = 8'h08;
  localparam logic [7:0] FPK_OFF_LED_HI = 8'h70;
  localparam logic [7:0] FPK_OFF_LED_LO = 8'h74;
  localparam logic [7:0] FPK_OFF_OUTBYTE = 8'hF4;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int FPK_POLL_KEY_BIT = 0;
  localparam int FPK_POLL_TUNE_BIT = 3;
  localparam int FPK_LED_RST_BIT = 3;
  localparam int FPK_LED_GRAT_BIT = 8;
  localparam int FPK_DIR_BIT = 7;
  // ----------------------------------------
  // sizes and reset values
  // ----------------------------------------
  localparam int FPK_ROWS = 10;
  localparam int FPK_WIDE_ROWS = 4;
  localparam int FPK_LED_BITS = 40;
  localparam logic [7:0] FPK_ROW_OPEN = 8'hFF;
  localparam logic [39:0] FPK_LED_RST = 40'h00_0000_0000;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int FPK_CLK_MHZ = 10;
  localparam int FPK_DEB_US = 1000;
  localparam int FPK_RST_MS = 10;
  localparam int FPK_SETTLE_CYC = 4;
  localparam int FPK_DEB_CYC = FPK_DEB_US * FPK_CLK_MHZ;
  localparam int FPK_RST_CYC = FPK_RST_MS * 1000 * FPK_CLK_MHZ;
endpackage
`default_nettype wire

// ==== src/fpk_scanner.sv ====
// front-panel key scanner: matrix scan, knob decode, service request, led bank
// Function
// - write at 74 loads indicator image and shifts it into the led chain.
// - graticule indicator output also enables the graticule lamp supply.
// - read at F4 returns the latched output byte, output only.
// - indicator bit 3 held over 10 ms resets the scanner controller.
// - ten rows: four of eight columns, six of seven columns.
// - one row driven low at a time, columns sampled, closed reads 0.
// - eight-bit column port; four-bit row code decoded to ten low drives.
// - knob phases sampled; direction from previous and current phases by xor.
// - key code latched drives key request low; tune code drives tune request low.
// - key request sets pending flag pulling shared service request low until cleared.
// - poll read shows low on bit 0 for key, bit 3 for tune pending.
// - poll write of 0 on a bit clears that pending flag; the request stays low until the output byte is read.
// - master read of output byte returns request high before next output.
// - clear decoded from poll write; tune path handled like key path.
// - every key or knob change is debounced by the internal timer.
// - ghost closures from rectangle corners are accounted for.
// - controller runs from its own system clock.
// - new closure addresses stacked, translated to key codes, output to master.
// - direction bit becomes msb of the tuning code byte.
// - beyond first scan, more than one queued closure aborts output.
// - debounce waits about 1 ms, rescans row, accepts only on match.
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module fpk_scanner #(
  parameter int STACK_DEPTH = 8,
  parameter logic [16:0] DEB_CYC = 17'(fpk_pkg::FPK_DEB_CYC),
  parameter logic [16:0] RST_CYC = 17'(fpk_pkg::FPK_RST_CYC)
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] column_input_port,
  input wire logic knob_phase_a,
  input wire logic knob_phase_b,
  output logic [3:0] row_select_code,
  output logic [fpk_pkg::FPK_ROWS-1:0] row_pull_oe_n,
  output logic key_request_out,
  output logic tune_request_out,
  output logic service_request_line_oe_n,
  output logic led_sdata,
  output logic led_sclk,
  output logic led_latch,
  output logic graticule_lamp_enable
);
  import fpk_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [7:0] {
    FPK_SETTLE = 8'h01,
    FPK_SAMPLE = 8'h02,
    FPK_DEB = 8'h04,
    FPK_RESCAN = 8'h08,
    FPK_COLS = 8'h10,
    FPK_CHECK = 8'h20,
    FPK_OUT = 8'h40,
    FPK_WAIT = 8'h80
  } fpk_st_t;

  typedef struct packed {
    fpk_st_t st;
    logic [3:0] row;
    logic [2:0] col;
    logic [16:0] tmr;
    logic [7:0] samp;
    logic [FPK_ROWS-1:0][7:0] img;
    logic [STACK_DEPTH-1:0][6:0] stk;
    logic [4:0] cnt;
    logic first;
    logic drain;
    logic [7:0] outb;
    logic key_req_n;
    logic tune_req_n;
    logic pend_k;
    logic pend_t;
    logic [7:0] col_s1;
    logic [7:0] col_s2;
    logic [1:0] kn_s1;
    logic [1:0] kn_s2;
    logic [1:0] kn_cand;
    logic [1:0] kn_stable;
    logic [16:0] kn_tmr;
    logic tune_q;
    logic [7:0] tune_code;
    logic [39:0] led_img;
    logic [39:0] led_sh;
    logic [39:0] led_out;
    logic [5:0] led_cnt;
    logic led_clk;
    logic led_latch;
    logic [16:0] rst_cnt;
    logic ack;
    logic [31:0] dat;
  } fpk_state_t;

  fpk_state_t s_q;
  fpk_state_t s_d;

  logic bus_req;
  logic wr_poll;
  logic rd_out;
  logic ctl_rst;
  logic [7:0] row_mask;
  logic [7:0] cur_row;
  logic kn_acc;
  logic wr_led;

  assign bus_req = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign wr_poll = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == FPK_OFF_POLL);
  assign rd_out = bus_req & ~wb_we_i & (wb_adr_i == FPK_OFF_OUTBYTE);
  assign wr_led = bus_req & wb_we_i & (wb_adr_i == FPK_OFF_LED_LO);
  assign ctl_rst = (s_q.rst_cnt == RST_CYC);
  // short rows have no eighth column; force it open
  assign row_mask = (s_q.row < 4'(FPK_WIDE_ROWS)) ? 8'h00 : 8'h80;
  assign cur_row = s_q.col_s2 | row_mask;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    kn_acc = 1'b0;
    s_d.ack = bus_req;
    s_d.led_latch = 1'b0;
    // synchronisers: first stage read only by the second
    s_d.col_s1 = column_input_port;
    s_d.col_s2 = s_q.col_s1;
    s_d.kn_s1 = {knob_phase_a, knob_phase_b};
    s_d.kn_s2 = s_q.kn_s1;

    // bus slave
    if (bus_req) begin
      s_d.dat = 32'h0000_0000;
      unique case (wb_adr_i)
        FPK_OFF_POLL: s_d.dat = {28'h000_0000, ~s_q.pend_t, 2'b00, ~s_q.pend_k};
        FPK_OFF_STATUS: s_d.dat = {28'h000_0000, s_q.first, ~service_request_line_oe_n,
                                   s_q.tune_req_n, s_q.key_req_n};
        FPK_OFF_LED_HI: s_d.dat = {24'h00_0000, s_q.led_img[39:32]};
        FPK_OFF_LED_LO: s_d.dat = s_q.led_img[31:0];
        FPK_OFF_OUTBYTE: s_d.dat = {24'h00_0000, s_q.outb};
        default: s_d.dat = 32'h0000_0000;
      endcase
      if (wb_we_i) begin
        s_d.dat = 32'h0000_0000;
        if (wb_adr_i == FPK_OFF_LED_HI && wb_sel_i[0]) begin
          s_d.led_img[39:32] = wb_dat_i[7:0];
        end
        if (wb_adr_i == FPK_OFF_LED_LO) begin
          for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
              s_d.led_img[b*8 +: 8] = wb_dat_i[b*8 +: 8];
            end
          end
          // whole chain reloaded on every write at 74, not on a write at 70
          s_d.led_sh = s_d.led_img;
          s_d.led_cnt = 6'(FPK_LED_BITS);
          s_d.led_clk = 1'b0;
        end
      end
    end

    // led chain: data set while clock low, shifted after the rising half
    // a reload write wins over the running shift, so the chain restarts cleanly
    if (s_q.led_cnt != 6'h00 && !wr_led) begin
      s_d.led_clk = ~s_q.led_clk;
      if (s_q.led_clk) begin
        s_d.led_sh = {s_q.led_sh[38:0], 1'b0};
        s_d.led_cnt = s_q.led_cnt - 6'h01;
        if (s_q.led_cnt == 6'h01) begin
          s_d.led_latch = 1'b1;
          s_d.led_out = s_q.led_img;
        end
      end
    end

    // controller reset by long hold of bit 3
    if (s_q.led_img[FPK_LED_RST_BIT]) begin
      if (!ctl_rst) begin
        s_d.rst_cnt = s_q.rst_cnt + 17'h0_0001;
      end
    end else begin
      s_d.rst_cnt = 17'h0_0000;
    end

    // knob: stable for the debounce time before accepted, in every state
    if (s_q.kn_s2 != s_q.kn_cand) begin
      s_d.kn_cand = s_q.kn_s2;
      s_d.kn_tmr = 17'h0_0000;
    end else if (s_q.kn_cand != s_q.kn_stable) begin
      s_d.kn_tmr = s_q.kn_tmr + 17'h0_0001;
      if (s_q.kn_tmr >= DEB_CYC) begin
        s_d.kn_stable = s_q.kn_cand;
        s_d.tune_q = 1'b1;
        kn_acc = 1'b1;
        // previous phase a against current phase b
        s_d.tune_code = {s_q.kn_stable[1] ^ s_q.kn_cand[0], 5'h00, s_q.kn_cand};
      end
    end

    // scan sequencer
    unique case (s_q.st)
      FPK_SETTLE: begin
        s_d.tmr = s_q.tmr + 17'h0_0001;
        if (s_q.tmr >= 17'(FPK_SETTLE_CYC)) begin
          s_d.st = FPK_SAMPLE;
        end
      end
      FPK_SAMPLE: begin
        s_d.samp = cur_row;
        s_d.tmr = 17'h0_0000;
        if (cur_row != s_q.img[s_q.row]) begin
          s_d.st = FPK_DEB;
        end else begin
          s_d.st = (s_q.row == 4'(FPK_ROWS - 1)) ? FPK_CHECK : FPK_SETTLE;
          s_d.row = (s_q.row == 4'(FPK_ROWS - 1)) ? 4'h0 : s_q.row + 4'h1;
        end
      end
      FPK_DEB: begin
        s_d.tmr = s_q.tmr + 17'h0_0001;
        if (s_q.tmr >= DEB_CYC) begin
          s_d.st = FPK_RESCAN;
        end
      end
      FPK_RESCAN: begin
        s_d.tmr = 17'h0_0000;
        s_d.col = 3'h0;
        if (cur_row == s_q.samp) begin
          s_d.st = FPK_COLS;
        end else begin
          s_d.st = (s_q.row == 4'(FPK_ROWS - 1)) ? FPK_CHECK : FPK_SETTLE;
          s_d.row = (s_q.row == 4'(FPK_ROWS - 1)) ? 4'h0 : s_q.row + 4'h1;
        end
      end
      FPK_COLS: begin
        // an overflowing stack drops the closure; past the first scan the abort discards it anyway
        if (s_q.img[s_q.row][s_q.col] && !s_q.samp[s_q.col] && s_q.cnt < 5'(STACK_DEPTH)) begin
          s_d.stk[s_q.cnt[$clog2(STACK_DEPTH)-1:0]] = {s_q.row, s_q.col};
          s_d.cnt = s_q.cnt + 5'h01;
        end
        s_d.img[s_q.row][s_q.col] = s_q.samp[s_q.col];
        s_d.col = s_q.col + 3'h1;
        if (s_q.col == 3'h7) begin
          s_d.st = (s_q.row == 4'(FPK_ROWS - 1)) ? FPK_CHECK : FPK_SETTLE;
          s_d.row = (s_q.row == 4'(FPK_ROWS - 1)) ? 4'h0 : s_q.row + 4'h1;
        end
      end
      FPK_CHECK: begin
        if (s_q.cnt == 5'h00 && !s_q.tune_q) begin
          s_d.first = 1'b0;
          s_d.drain = 1'b0;
          s_d.st = FPK_SETTLE;
        end else if (!s_q.first && !s_q.drain && s_q.cnt > 5'h01) begin
          // several closures in one pass are likely ghosts
          s_d.cnt = 5'h00;
          s_d.st = s_q.tune_q ? FPK_OUT : FPK_SETTLE;
        end else begin
          s_d.st = FPK_OUT;
        end
      end
      FPK_OUT: begin
        s_d.drain = 1'b1;
        if (s_q.tune_q) begin
          s_d.outb = s_q.tune_code;
          s_d.tune_req_n = 1'b0;
          // a code accepted in this very cycle stays queued: set wins over clear
          s_d.tune_q = kn_acc;
          s_d.st = FPK_WAIT;
        end else begin
          s_d.outb = {1'b0, s_q.stk[0]};
          for (int i = 0; i < STACK_DEPTH - 1; i++) begin
            s_d.stk[i] = s_q.stk[i+1];
          end
          s_d.cnt = s_q.cnt - 5'h01;
          s_d.key_req_n = 1'b0;
          s_d.st = FPK_WAIT;
        end
      end
      FPK_WAIT: begin
        // output byte held until the read is seen
        if (rd_out) begin
          s_d.key_req_n = 1'b1;
          s_d.tune_req_n = 1'b1;
          s_d.st = FPK_CHECK;
        end
      end
    endcase

    // pending flags: a new request wins over a clear in the same cycle
    s_d.pend_k = (s_q.key_req_n & ~s_d.key_req_n) |
                 (s_q.pend_k & ~(wr_poll & ~wb_dat_i[FPK_POLL_KEY_BIT]));
    s_d.pend_t = (s_q.tune_req_n & ~s_d.tune_req_n) |
                 (s_q.pend_t & ~(wr_poll & ~wb_dat_i[FPK_POLL_TUNE_BIT]));

    if (ctl_rst) begin
      s_d.st = FPK_SETTLE;
      s_d.row = 4'h0;
      s_d.tmr = 17'h0_0000;
      s_d.img = {FPK_ROWS{FPK_ROW_OPEN}};
      s_d.cnt = 5'h00;
      s_d.first = 1'b1;
      s_d.drain = 1'b0;
      s_d.key_req_n = 1'b1;
      s_d.tune_req_n = 1'b1;
      s_d.tune_q = 1'b0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.st <= FPK_SETTLE;
      s_q.img <= {FPK_ROWS{FPK_ROW_OPEN}};
      s_q.first <= 1'b1;
      s_q.key_req_n <= 1'b1;
      s_q.tune_req_n <= 1'b1;
      s_q.led_img <= FPK_LED_RST;
      s_q.led_out <= FPK_LED_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.dat;
  assign row_select_code = s_q.row;
  generate
    for (genvar r = 0; r < FPK_ROWS; r++) begin : g_row
      assign row_pull_oe_n[r] = (s_q.row != 4'(r));
    end
  endgenerate
  assign key_request_out = s_q.key_req_n;
  assign tune_request_out = s_q.tune_req_n;
  assign service_request_line_oe_n = ~(s_q.pend_k | s_q.pend_t);
  assign led_sdata = s_q.led_sh[39];
  assign led_sclk = s_q.led_clk;
  assign led_latch = s_q.led_latch;
  assign graticule_lamp_enable = s_q.led_out[FPK_LED_GRAT_BIT];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  one_row_a: assert property ($onehot(~row_pull_oe_n) && row_select_code <= 4'h9)
    else $error("row drive not single");
  svc_req_set_a: assert property ($fell(key_request_out) |=> !service_request_line_oe_n)
    else $error("service request not raised");
  read_rel_a: assert property (s_q.st == FPK_WAIT && rd_out |=> key_request_out && tune_request_out)
    else $error("request not released on read");
  out_hold_a: assert property (!key_request_out && $past(!key_request_out) |-> $stable(s_q.outb))
    else $error("output byte changed while pending");
  grat_a: assert property (led_latch |-> graticule_lamp_enable == s_q.led_img[FPK_LED_GRAT_BIT])
    else $error("lamp enable not from latched chain");
  dir_msb_a: assert property ($rose(s_q.tune_q) |->
    s_q.tune_code[FPK_DIR_BIT] == ($past(s_q.kn_stable[1]) ^ s_q.kn_stable[0]))
    else $error("direction bit wrong");
  ctl_rst_a: assert property (ctl_rst |=> key_request_out && tune_request_out && s_q.first)
    else $error("controller reset ineffective");
  clr_a: assert property (wr_poll && !wb_dat_i[FPK_POLL_KEY_BIT] && s_q.st != FPK_OUT |=> !s_q.pend_k)
    else $error("poll clear ignored");

  key_req_c: cover property ($fell(key_request_out));
  tune_req_c: cover property ($fell(tune_request_out));
  abort_c: cover property (s_q.st == FPK_CHECK && !s_q.first && !s_q.drain && s_q.cnt > 5'h01);
endmodule
`default_nettype wire

// ==== tb/fpk_matrix_model.sv ====
// key matrix model: pulled-up columns, one driven row at a time
`timescale 1ns/1ps
`default_nettype none
module fpk_matrix_model (
  input wire logic [9:0] row_pull_oe_n,
  input wire logic [79:0] key_closed,
  output logic [7:0] column_input_port
);
  // ----------------------------------------
  // column levels
  // ----------------------------------------
  // open columns float up through the pull-ups, never hold an old value
  always_comb begin
    column_input_port = 8'hFF;
    for (int r = 0; r < 10; r++) begin
      for (int c = 0; c < 8; c++) begin
        // narrow rows have no eighth column
        if (row_pull_oe_n[r] === 1'b0 && key_closed[r*8+c] && (r < 4 || c < 7)) begin
          column_input_port[c] = 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/front_panel_key_scanner_tb.sv ====
// self-checking bench for the front-panel key scanner
`timescale 1ns/1ps
`default_nettype none
module front_panel_key_scanner_tb;
  import fpk_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_sys = 0;
  logic arst_n = 0;
  logic cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, ka = 0, kb = 0, key_rq, tune_rq, svc_oe_n, sdata, sclk, latch, lamp;
  logic [7:0] cols;
  logic [3:0] row_code;
  logic [9:0] row_oe_n;
  logic [79:0] keys = 80'h0;
  logic [39:0] led_cap = 40'h0;
  int err_count = 0, checked = 0;
  logic [7:0] exp_q[$];
  always #50 clk_sys = ~clk_sys;
  fpk_scanner #(.STACK_DEPTH(8), .DEB_CYC(17'd20), .RST_CYC(17'd50)) fpk_scanner_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .column_input_port(cols), .knob_phase_a(ka), .knob_phase_b(kb), .row_select_code(row_code),
    .row_pull_oe_n(row_oe_n), .key_request_out(key_rq), .tune_request_out(tune_rq),
    .service_request_line_oe_n(svc_oe_n), .led_sdata(sdata), .led_sclk(sclk),
    .led_latch(latch), .graticule_lamp_enable(lamp));
  fpk_matrix_model fpk_matrix_model_inst (.row_pull_oe_n(row_oe_n), .key_closed(keys),
    .column_input_port(cols));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // classic single cycle; waits for ack without assuming a latency
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n = 0;
    @(posedge clk_sys);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n == 100) err_count++;
    r = rdat;
    cyc <= 0; stb <= 0;
  endtask
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  // poll, clear and read one request, the way the master services it
  task automatic serve(input bit tune);
    int n = 0;
    logic [31:0] pv;
    while ((tune ? tune_rq : key_rq) !== 1'b0 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 5000) err_count++;
    wait_cyc(2);
    chk(svc_oe_n, 1'b0);
    pv = tune ? 32'h01 : 32'h08;
    bus(0, FPK_OFF_POLL, 0, q);
    chk(q, pv);
    bus(1, FPK_OFF_POLL, pv, q);
    wait_cyc(2);
    chk(svc_oe_n, 1'b1);
    chk(tune ? tune_rq : key_rq, 1'b0);
    bus(0, FPK_OFF_OUTBYTE, 0, q);
    chk(q, exp_q.pop_front());
    wait_cyc(1);
    chk(tune ? tune_rq : key_rq, 1'b1);
  endtask
  // ----------------------------------------
  // monitors and watchdog
  // ----------------------------------------
  always @(posedge sclk) led_cap <= {led_cap[38:0], sdata};
  always @(negedge clk_sys) if (arst_n) chk(row_oe_n, ~(40'h1 << row_code) & 40'h3FF);
  initial begin
    #(40000 * 100);
    err_count++;
    stop_test();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    int row, col, ki, ni, n;
    int g[4];
    g = '{0, 1, 3, 2};
    void'($urandom(43));
    wait_cyc(8);
    arst_n <= 1;
    wait_cyc(2);
    chk({key_rq, tune_rq, svc_oe_n, lamp}, 4'hE);
    bus(0, FPK_OFF_POLL, 0, q);
    chk(q, 32'h09);
    bus(0, 8'h40, 0, q);
    chk(q, 32'h0);
    $display("test reset done");
    // single random key closure, held past debounce
    row = $urandom % 10;
    col = $urandom % (row < 4 ? 8 : 7);
    keys[row*8+col] <= 1'b1;
    exp_q.push_back({1'b0, row[3:0], col[2:0]});
    serve(0);
    keys <= 80'h0;
    wait_cyc(800);
    $display("test key done");
    // two new closures in one pass are abandoned
    keys[3*8+1] <= 1'b1;
    keys[3*8+4] <= 1'b1;
    wait_cyc(1500);
    chk(key_rq, 1'b1);
    keys <= 80'h0;
    wait_cyc(800);
    $display("test ghost done");
    // knob steps in random direction
    ki = 0;
    for (int s = 0; s < 6; s++) begin
      ni = ($urandom % 2) ? (ki + 1) % 4 : (ki + 3) % 4;
      ka <= g[ni][1];
      kb <= g[ni][0];
      exp_q.push_back({g[ki][1] ^ g[ni][0], 5'h00, g[ni][1:0]});
      serve(1);
      ki = ni;
    end
    $display("test knob done");
    // led chain reload, lamp enable and held controller reset
    bus(1, FPK_OFF_LED_HI, 32'hA5, q);
    bus(1, FPK_OFF_LED_LO, 32'h0000010D, q);
    n = 0;
    while (latch !== 1'b1 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    wait_cyc(2);
    chk(led_cap, 40'hA5_0000_010D);
    chk(lamp, 1'b1);
    bus(0, FPK_OFF_LED_LO, 0, q);
    chk(q, 32'h0000010D);
    wait_cyc(100);
    bus(0, FPK_OFF_STATUS, 0, q);
    chk(q[3:0], 4'hB);
    bus(1, FPK_OFF_LED_LO, 32'h0, q);
    wait_cyc(200);
    chk(lamp, 1'b0);
    chk(led_cap, 40'hA5_0000_0000);
    $display("test led done");
    stop_test();
  end
endmodule
`default_nettype wire
